// file: verilog/pmic_irq_pkg.sv
// constants for the fault, thermal and power button interrupt bank
`default_nettype none
package pmic_irq_pkg;

  // register offsets on the management port
  localparam logic [7:0] REG_FAULT_STATUS_ADDR = 8'h18;
  localparam logic [7:0] REG_FAULT_MASK_ADDR   = 8'h19;
  localparam logic [7:0] REG_FAULT_SENSE_ADDR  = 8'h1a;
  localparam logic [7:0] THERMAL_STATUS_ADDR   = 8'h20;
  localparam logic [7:0] THERMAL_MASK_ADDR     = 8'h21;
  localparam logic [7:0] THERMAL_SENSE_ADDR    = 8'h22;
  localparam logic [7:0] BUTTON_STATUS_ADDR    = 8'h24;
  localparam logic [7:0] BUTTON_MASK_ADDR      = 8'h25;
  localparam logic [7:0] BUTTON_SENSE_ADDR     = 8'h26;

  // implemented bits of each group
  localparam logic [7:0] REG_FAULT_VALID = 8'h07;
  localparam logic [7:0] THERMAL_VALID   = 8'h05;
  localparam logic [7:0] BUTTON_VALID    = 8'h3f;

  // mask reset values: every implemented mask bit starts set
  localparam logic [7:0] REG_FAULT_MASK_RESET = 8'h07;
  localparam logic [7:0] THERMAL_MASK_RESET   = 8'h05;
  localparam logic [7:0] BUTTON_MASK_RESET    = 8'h3f;

  // field positions
  localparam int HOT_WARN_BIT   = 0;
  localparam int HOT_CRIT_BIT   = 2;
  localparam int BTN_CHANGE_BIT = 0;
  localparam int BTN_HOLD_BASE  = 1;
  localparam int NUM_REG        = 3;
  localparam int NUM_HOLD       = 5;

  // timing
  localparam int CLK_FREQ_KHZ   = 200000;
  localparam int HOLD_A_MS      = 1000;
  localparam int HOLD_B_MS      = 2000;
  localparam int HOLD_C_MS      = 3000;
  localparam int HOLD_D_MS      = 4000;
  localparam int HOLD_E_MS      = 8000;
  localparam int HOLD_A_CYCLES  = HOLD_A_MS * CLK_FREQ_KHZ;
  localparam int HOLD_B_CYCLES  = HOLD_B_MS * CLK_FREQ_KHZ;
  localparam int HOLD_C_CYCLES  = HOLD_C_MS * CLK_FREQ_KHZ;
  localparam int HOLD_D_CYCLES  = HOLD_D_MS * CLK_FREQ_KHZ;
  localparam int HOLD_E_CYCLES  = HOLD_E_MS * CLK_FREQ_KHZ;
  localparam int DEB_WIDTH      = 16;
  localparam int HOLD_CNT_WIDTH = 32;

endpackage
`default_nettype wire

// file: verilog/button_press_timer.sv
// debounce of the power button and hold-time event generation
`timescale 1ns/1ps
`default_nettype none
module button_press_timer #(
  parameter int DEB_W    = pmic_irq_pkg::DEB_WIDTH,
  parameter int HOLD_A   = pmic_irq_pkg::HOLD_A_CYCLES,
  parameter int HOLD_B   = pmic_irq_pkg::HOLD_B_CYCLES,
  parameter int HOLD_C   = pmic_irq_pkg::HOLD_C_CYCLES,
  parameter int HOLD_D   = pmic_irq_pkg::HOLD_D_CYCLES,
  parameter int HOLD_E   = pmic_irq_pkg::HOLD_E_CYCLES
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_pressed,
  input  wire logic [DEB_W-1:0] i_fall_debounce,
  input  wire logic [DEB_W-1:0] i_rise_debounce,
  output logic                  o_pressed_live,
  output logic                  o_change,
  output logic [4:0]            o_hold_live,
  output logic [4:0]            o_hold_hit
);

  localparam int CW = pmic_irq_pkg::HOLD_CNT_WIDTH;
  localparam logic [4:0][CW-1:0] HOLD_THR = {CW'(HOLD_E), CW'(HOLD_D), CW'(HOLD_C), CW'(HOLD_B), CW'(HOLD_A)};

  if (HOLD_A < 1 || HOLD_B < HOLD_A || HOLD_C < HOLD_B || HOLD_D < HOLD_C || HOLD_E < HOLD_D) begin : g_bad_hold
    $error("hold thresholds must be positive and ascending");
  end
  if (DEB_W < 1 || DEB_W > 31) begin : g_bad_deb
    $error("debounce width out of range");
  end

  typedef struct packed {
    logic             pressed_live;
    logic             change;
    logic [DEB_W-1:0] deb_cnt;
    logic [CW-1:0]    hold_cnt;
    logic [4:0]       hold_live;
    logic [4:0]       hold_hit;
  } timer_state_type;

  timer_state_type state;
  timer_state_type next;

  logic [DEB_W-1:0] deb_limit;

  always_comb begin
    next = state;
    next.change = 1'b0;
    next.hold_hit = 5'h0;
    // press uses the falling-edge setting, release the rising-edge one
    deb_limit = i_pressed ? i_fall_debounce : i_rise_debounce;
    if (i_pressed != state.pressed_live) begin
      if (state.deb_cnt >= deb_limit) begin
        next.pressed_live = i_pressed;
        next.change = 1'b1;
        next.deb_cnt = '0;
      end else begin
        next.deb_cnt = state.deb_cnt + DEB_W'(1);
      end
    end else begin
      next.deb_cnt = '0;
    end
    if (state.pressed_live) begin
      if (state.hold_cnt < HOLD_THR[4]) begin
        next.hold_cnt = state.hold_cnt + CW'(1);
      end
      for (int k = 0; k < 5; k++) begin
        if (state.hold_cnt == HOLD_THR[k] && !state.hold_live[k]) begin
          next.hold_live[k] = 1'b1;
          next.hold_hit[k] = 1'b1;
        end
      end
    end else begin
      next.hold_cnt = '0;
      next.hold_live = 5'h0;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= '0;
    end else begin
      state <= next;
    end
  end

  assign o_pressed_live = state.pressed_live;
  assign o_change       = state.change;
  assign o_hold_live    = state.hold_live;
  assign o_hold_hit     = state.hold_hit;

  a_hold_released: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    $fell(state.pressed_live) |=> (state.hold_live == 5'h0) [*2])
    else $error("hold sense not cleared after release");

  a_hold_once: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (state.hold_hit & $past(state.hold_live)) == 5'h0)
    else $error("hold event fired twice in one press");

endmodule
`default_nettype wire

// file: verilog/pmic_fault_button_irq_bank.sv
// interrupt register bank: regulator current limit, die temperature, power button
`timescale 1ns/1ps
`default_nettype none
module pmic_fault_button_irq_bank #(
  parameter int DEB_W  = pmic_irq_pkg::DEB_WIDTH,
  parameter int HOLD_A = pmic_irq_pkg::HOLD_A_CYCLES,
  parameter int HOLD_B = pmic_irq_pkg::HOLD_B_CYCLES,
  parameter int HOLD_C = pmic_irq_pkg::HOLD_C_CYCLES,
  parameter int HOLD_D = pmic_irq_pkg::HOLD_D_CYCLES,
  parameter int HOLD_E = pmic_irq_pkg::HOLD_E_CYCLES
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_rst_n,
  // detector levels from the analog side, asynchronous
  input  wire logic [2:0]       i_reg_ilim_fault,
  input  wire logic             i_hot_warn_above,
  input  wire logic             i_hot_crit_above,
  input  wire logic             i_power_button_n,
  // debounce settings in clock cycles
  input  wire logic [DEB_W-1:0] i_fall_debounce,
  input  wire logic [DEB_W-1:0] i_rise_debounce,
  // register port of the management interface
  input  wire logic [7:0]       i_reg_addr,
  input  wire logic             i_reg_wr,
  input  wire logic [7:0]       i_reg_wdata,
  input  wire logic             i_reg_rd,
  output logic [7:0]            o_reg_rdata,
  output logic                  o_irq_out_n
);

  typedef struct packed {
    logic [2:0] ilim_s1;
    logic [2:0] ilim_s2;
    logic [2:0] ilim_live;
    logic [1:0] hot_s1;
    logic [1:0] hot_s2;
    logic [1:0] hot_live;
    logic       btn_s1;
    logic       btn_s2;
    logic [7:0] reg_stat;
    logic [7:0] reg_mask;
    logic [7:0] hot_stat;
    logic [7:0] hot_mask;
    logic [7:0] btn_stat;
    logic [7:0] btn_mask;
    logic [7:0] rdata;
    logic       irq_n;
  } bank_state_type;

  localparam bank_state_type BANK_RESET = '{
    ilim_s1:   3'h0,
    ilim_s2:   3'h0,
    ilim_live: 3'h0,
    hot_s1:    2'h0,
    hot_s2:    2'h0,
    hot_live:  2'h0,
    btn_s1:    1'b1,
    btn_s2:    1'b1,
    reg_stat:  8'h00,
    reg_mask:  pmic_irq_pkg::REG_FAULT_MASK_RESET,
    hot_stat:  8'h00,
    hot_mask:  pmic_irq_pkg::THERMAL_MASK_RESET,
    btn_stat:  8'h00,
    btn_mask:  pmic_irq_pkg::BUTTON_MASK_RESET,
    rdata:     8'h00,
    irq_n:     1'b1
  };

  bank_state_type state;
  bank_state_type next;

  logic       btn_pressed_live;
  logic       btn_change;
  logic [4:0] btn_hold_live;
  logic [4:0] btn_hold_hit;
  logic [2:0] ilim_rise;
  logic [1:0] hot_cross;
  logic [7:0] reg_set;
  logic [7:0] hot_set;
  logic [7:0] btn_set;
  logic [7:0] hot_sense;
  logic [7:0] btn_sense;

  // bits that software clears in a status register this cycle
  function automatic logic [7:0] clear_bits(input logic [7:0] own_addr, input logic [7:0] stat);
    logic [7:0] clr;
    clr = 8'h00;
    if (i_reg_addr == own_addr) begin
      if (i_reg_wr) begin
        clr = clr | i_reg_wdata;
      end
      if (i_reg_rd) begin
        clr = clr | stat;
      end
    end
    return clr;
  endfunction

  // sticky update, set wins over clear
  function automatic logic [7:0] sticky(input logic [7:0] stat, input logic [7:0] set,
                                        input logic [7:0] clr, input logic [7:0] valid);
    return ((stat & ~clr) | set) & valid;
  endfunction

  if (pmic_irq_pkg::BTN_HOLD_BASE + pmic_irq_pkg::NUM_HOLD > 8) begin : g_bad_layout
    $error("button fields exceed the register width");
  end

  button_press_timer #(
    .DEB_W  (DEB_W),
    .HOLD_A (HOLD_A),
    .HOLD_B (HOLD_B),
    .HOLD_C (HOLD_C),
    .HOLD_D (HOLD_D),
    .HOLD_E (HOLD_E)
  ) u_button_press_timer (
    .i_ref_clk       (i_ref_clk),
    .i_rst_n         (i_rst_n),
    .i_pressed       (~state.btn_s2),
    .i_fall_debounce (i_fall_debounce),
    .i_rise_debounce (i_rise_debounce),
    .o_pressed_live  (btn_pressed_live),
    .o_change        (btn_change),
    .o_hold_live     (btn_hold_live),
    .o_hold_hit      (btn_hold_hit)
  );

  // entry into current limit and threshold crossings in either direction
  assign ilim_rise = state.ilim_s2 & ~state.ilim_live;
  assign hot_cross = state.hot_s2 ^ state.hot_live;

  always_comb begin
    reg_set = 8'h00;
    reg_set[2:0] = ilim_rise;
    hot_set = 8'h00;
    hot_set[pmic_irq_pkg::HOT_WARN_BIT] = hot_cross[0];
    hot_set[pmic_irq_pkg::HOT_CRIT_BIT] = hot_cross[1];
    btn_set = 8'h00;
    btn_set[pmic_irq_pkg::BTN_CHANGE_BIT] = btn_change;
    btn_set[pmic_irq_pkg::BTN_HOLD_BASE +: pmic_irq_pkg::NUM_HOLD] = btn_hold_hit;
    hot_sense = 8'h00;
    hot_sense[pmic_irq_pkg::HOT_WARN_BIT] = state.hot_live[0];
    hot_sense[pmic_irq_pkg::HOT_CRIT_BIT] = state.hot_live[1];
    btn_sense = 8'h00;
    btn_sense[pmic_irq_pkg::BTN_CHANGE_BIT] = btn_pressed_live;
    btn_sense[pmic_irq_pkg::BTN_HOLD_BASE +: pmic_irq_pkg::NUM_HOLD] = btn_hold_live;
  end

  always_comb begin
    next = state;
    // two-flop synchronisers, third stage is the live copy of the fault and thermal levels
    next.ilim_s1   = i_reg_ilim_fault;
    next.ilim_s2   = state.ilim_s1;
    next.ilim_live = state.ilim_s2;
    next.hot_s1    = {i_hot_crit_above, i_hot_warn_above};
    next.hot_s2    = state.hot_s1;
    next.hot_live  = state.hot_s2;
    next.btn_s1    = i_power_button_n;
    next.btn_s2    = state.btn_s1;

    next.reg_stat = sticky(state.reg_stat, reg_set,
                           clear_bits(pmic_irq_pkg::REG_FAULT_STATUS_ADDR, state.reg_stat),
                           pmic_irq_pkg::REG_FAULT_VALID);
    next.hot_stat = sticky(state.hot_stat, hot_set,
                           clear_bits(pmic_irq_pkg::THERMAL_STATUS_ADDR, state.hot_stat),
                           pmic_irq_pkg::THERMAL_VALID);
    next.btn_stat = sticky(state.btn_stat, btn_set,
                           clear_bits(pmic_irq_pkg::BUTTON_STATUS_ADDR, state.btn_stat),
                           pmic_irq_pkg::BUTTON_VALID);

    if (i_reg_wr) begin
      unique case (i_reg_addr)
        pmic_irq_pkg::REG_FAULT_MASK_ADDR: begin
          next.reg_mask = i_reg_wdata & pmic_irq_pkg::REG_FAULT_VALID;
        end
        pmic_irq_pkg::THERMAL_MASK_ADDR: begin
          next.hot_mask = i_reg_wdata & pmic_irq_pkg::THERMAL_VALID;
        end
        pmic_irq_pkg::BUTTON_MASK_ADDR: begin
          next.btn_mask = i_reg_wdata & pmic_irq_pkg::BUTTON_VALID;
        end
        default: begin
          next.reg_mask = state.reg_mask;
        end
      endcase
    end

    // read data is captured on the read strobe and held until the next read
    if (i_reg_rd) begin
      unique case (i_reg_addr)
        pmic_irq_pkg::REG_FAULT_STATUS_ADDR: next.rdata = state.reg_stat;
        pmic_irq_pkg::REG_FAULT_MASK_ADDR:   next.rdata = state.reg_mask;
        pmic_irq_pkg::REG_FAULT_SENSE_ADDR:  next.rdata = {5'h00, state.ilim_live};
        pmic_irq_pkg::THERMAL_STATUS_ADDR:   next.rdata = state.hot_stat;
        pmic_irq_pkg::THERMAL_MASK_ADDR:     next.rdata = state.hot_mask;
        pmic_irq_pkg::THERMAL_SENSE_ADDR:    next.rdata = hot_sense;
        pmic_irq_pkg::BUTTON_STATUS_ADDR:    next.rdata = state.btn_stat;
        pmic_irq_pkg::BUTTON_MASK_ADDR:      next.rdata = state.btn_mask;
        pmic_irq_pkg::BUTTON_SENSE_ADDR:     next.rdata = btn_sense;
        default:                             next.rdata = 8'h00;
      endcase
    end

    // low while any unmasked status bit is set
    next.irq_n = ~(|(next.reg_stat & ~next.reg_mask)
                 | |(next.hot_stat & ~next.hot_mask)
                 | |(next.btn_stat & ~next.btn_mask));
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= BANK_RESET;
    end else begin
      state <= next;
    end
  end

  assign o_reg_rdata = state.rdata;
  assign o_irq_out_n = state.irq_n;

  a_irq_level: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    o_irq_out_n == !((|(state.reg_stat & ~state.reg_mask)) || (|(state.hot_stat & ~state.hot_mask))
                     || (|(state.btn_stat & ~state.btn_mask))))
    else $error("interrupt output disagrees with unmasked status");

  a_mask_blocks: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (state.reg_mask == 8'h07 && state.hot_mask == 8'h05 && state.btn_mask == 8'h3f) |-> o_irq_out_n)
    else $error("fully masked bank pulls interrupt low");

  a_ilim_set: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (ilim_rise != 3'h0) |=> ((state.reg_stat[2:0] & $past(ilim_rise)) == $past(ilim_rise)))
    else $error("current limit entry not latched");

  a_write_clear: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_reg_wr && i_reg_addr == 8'h18 && i_reg_wdata[0] && !ilim_rise[0]) |=> !state.reg_stat[0])
    else $error("write one did not clear status");

  a_read_clear: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_reg_rd && i_reg_addr == 8'h24 && !btn_change && btn_hold_hit == 5'h0)
      |=> (state.btn_stat == 8'h00) && (o_reg_rdata == $past(state.btn_stat)))
    else $error("read did not return and clear button status");

  a_hot_cross: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    $changed(state.hot_live) |-> state.hot_stat[0] || state.hot_stat[2] || $past(i_reg_rd) || $past(i_reg_wr))
    else $error("temperature crossing not latched");

  a_sense_track: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_reg_rd && i_reg_addr == 8'h1a) |=> o_reg_rdata == {5'h00, $past(state.ilim_live)})
    else $error("regulator sense read wrong");

  a_button_change: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    btn_change |=> state.btn_stat[0])
    else $error("button change not latched");

  a_hold_set: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    btn_hold_hit[4] |=> state.btn_stat[5] ##1 (state.btn_stat[5] || $past(i_reg_rd) || $past(i_reg_wr)))
    else $error("long hold not latched");

  a_unused_zero: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    state.reg_stat[7:3] == 5'h00 && !state.hot_stat[1] && state.btn_stat[7:6] == 2'h0)
    else $error("unused status bit set");

  a_reg_mask_write: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_reg_wr && i_reg_addr == 8'h19) |=> state.reg_mask == ($past(i_reg_wdata) & 8'h07))
    else $error("regulator mask write lost");

  a_hot_mask_write: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_reg_wr && i_reg_addr == 8'h21) |=> state.hot_mask == ($past(i_reg_wdata) & 8'h05))
    else $error("thermal mask write lost");

  a_btn_mask_write: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_reg_wr && i_reg_addr == 8'h25) |=> state.btn_mask == ($past(i_reg_wdata) & 8'h3f))
    else $error("button mask write lost");

  a_reg_stat_kept: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    !(i_reg_addr == 8'h18 && (i_reg_rd || i_reg_wr)) |=> (state.reg_stat & $past(state.reg_stat)) == $past(state.reg_stat))
    else $error("regulator status lost without access");

  a_hot_stat_kept: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    !(i_reg_addr == 8'h20 && (i_reg_rd || i_reg_wr)) |=> (state.hot_stat & $past(state.hot_stat)) == $past(state.hot_stat))
    else $error("thermal status lost without access");

  a_btn_stat_kept: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    !(i_reg_addr == 8'h24 && (i_reg_rd || i_reg_wr)) |=> (state.btn_stat & $past(state.btn_stat)) == $past(state.btn_stat))
    else $error("button status lost without access");

  a_write_zero_keeps: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_reg_wr && !i_reg_rd && i_reg_addr == 8'h18 && i_reg_wdata == 8'h00)
      |=> (state.reg_stat & $past(state.reg_stat)) == $past(state.reg_stat))
    else $error("write of zero cleared status");

  a_hot_warn_set: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    hot_cross[0] |=> state.hot_stat[0])
    else $error("lower threshold crossing not latched");

  a_hot_crit_set: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    hot_cross[1] |=> state.hot_stat[2])
    else $error("upper threshold crossing not latched");

  a_hold_bits_set: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (btn_hold_hit != 5'h0) |=> ((state.btn_stat[5:1] & $past(btn_hold_hit)) == $past(btn_hold_hit)))
    else $error("hold event not latched");

  a_btn_sense_read: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_reg_rd && i_reg_addr == 8'h26) |=> o_reg_rdata == {2'h0, $past(btn_hold_live), $past(btn_pressed_live)})
    else $error("button sense read wrong");

  a_hot_sense_read: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_reg_rd && i_reg_addr == 8'h22) |=> o_reg_rdata == {5'h00, $past(state.hot_live[1]), 1'b0, $past(state.hot_live[0])})
    else $error("thermal sense read wrong");

  a_masked_high: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    ((state.reg_stat & ~state.reg_mask) == 8'h00 && (state.hot_stat & ~state.hot_mask) == 8'h00
     && (state.btn_stat & ~state.btn_mask) == 8'h00) |-> o_irq_out_n)
    else $error("interrupt low with nothing unmasked");

  a_unmasked_low: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    ((state.btn_stat & ~state.btn_mask) != 8'h00) |-> !o_irq_out_n)
    else $error("unmasked button status left interrupt high");

  a_hold_sense_clear: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    !btn_pressed_live |=> (btn_hold_live == 5'h0))
    else $error("hold sense kept after release");

  a_reg_read_data: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_reg_rd && i_reg_addr == 8'h18) |=> o_reg_rdata == $past(state.reg_stat))
    else $error("regulator status read wrong");

endmodule
`default_nettype wire

// file: testbench/host_model.sv
// host side model: register port master of the management interface
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic       i_ref_clk,
  input  wire logic [7:0] i_rdata,
  output logic [7:0]      o_addr,
  output logic            o_wr,
  output logic [7:0]      o_wdata,
  output logic            o_rd
);
  initial begin
    o_addr  = 8'h00;
    o_wr    = 1'b0;
    o_wdata = 8'h00;
    o_rd    = 1'b0;
  end

  // one write strobe cycle; a one in a status bit clears it
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_ref_clk);
    o_addr  = a;
    o_wdata = d;
    o_wr    = 1'b1;
    @(negedge i_ref_clk);
    o_wr    = 1'b0;
    o_wdata = ~d;
    o_addr  = ~a;
  endtask

  // one read strobe cycle; data is taken the cycle after
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge i_ref_clk);
    o_addr = a;
    o_rd   = 1'b1;
    @(negedge i_ref_clk);
    o_rd   = 1'b0;
    o_addr = ~a;
    d      = i_rdata;
  endtask
endmodule
`default_nettype wire

// file: testbench/tb_top.sv
// self-checking bench of the fault, thermal and button interrupt bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct {logic wr; logic [7:0] addr; logic [7:0] wdata; logic [7:0] exp;} row_type;
  logic        i_ref_clk;
  logic        i_rst_n;
  logic [2:0]  ilim;
  logic        warn;
  logic        crit;
  logic        btn_n;
  logic [15:0] fall_deb;
  logic [15:0] rise_deb;
  logic [7:0]  addr;
  logic        wr;
  logic [7:0]  wdata;
  logic        rd;
  logic [7:0]  rdata;
  logic        irq_n;
  int          fail_count;
  int          samples_checked;
  row_type rows[14] = '{'{1'b0, 8'h18, 8'h00, 8'h00}, '{1'b0, 8'h19, 8'h00, 8'h07}, '{1'b0, 8'h1a, 8'h00, 8'h00},
    '{1'b0, 8'h20, 8'h00, 8'h00}, '{1'b0, 8'h21, 8'h00, 8'h05}, '{1'b0, 8'h22, 8'h00, 8'h00},
    '{1'b0, 8'h24, 8'h00, 8'h00}, '{1'b0, 8'h25, 8'h00, 8'h3f}, '{1'b0, 8'h26, 8'h00, 8'h00},
    '{1'b0, 8'h30, 8'h00, 8'h00}, '{1'b1, 8'h19, 8'hff, 8'h07}, '{1'b1, 8'h22, 8'hff, 8'h00},
    '{1'b1, 8'h25, 8'hff, 8'h3f}, '{1'b1, 8'h21, 8'h00, 8'h00}};
  logic [1:0] tw[4] = '{2'b01, 2'b00, 2'b10, 2'b00};
  logic [7:0] exp_t[4] = '{8'h01, 8'h01, 8'h04, 8'h04};

  pmic_fault_button_irq_bank #(.HOLD_A(20), .HOLD_B(40), .HOLD_C(60), .HOLD_D(80), .HOLD_E(160)) DUT (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_reg_ilim_fault(ilim), .i_hot_warn_above(warn),
    .i_hot_crit_above(crit), .i_power_button_n(btn_n), .i_fall_debounce(fall_deb),
    .i_rise_debounce(rise_deb), .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_wdata(wdata),
    .i_reg_rd(rd), .o_reg_rdata(rdata), .o_irq_out_n(irq_n));

  host_model host (.i_ref_clk(i_ref_clk), .i_rdata(rdata), .o_addr(addr), .o_wr(wr), .o_wdata(wdata), .o_rd(rd));

  initial begin
    i_ref_clk = 1'b0;
    forever #2.5 i_ref_clk = ~i_ref_clk;
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string msg);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host.read_reg(a, d);
    check(d, exp, $sformatf("read %h", a));
  endtask

  // bounded wait for the interrupt line to reach a level
  task automatic wait_irq(input logic lvl);
    for (int n = 0; n < 100 && irq_n !== lvl; n++) @(negedge i_ref_clk);
    check({7'h00, irq_n}, {7'h00, lvl}, "irq level");
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    #100000;
    fail_count++;
    finish_test;
  end

  initial begin
    fail_count = 0;
    samples_checked = 0;
    i_rst_n = 1'b0;
    ilim = 3'b000;
    warn = 1'b0;
    crit = 1'b0;
    btn_n = 1'b1;
    fall_deb = 16'h0008;
    rise_deb = 16'h0002;
    repeat (3) @(posedge i_ref_clk);
    @(negedge i_ref_clk) i_rst_n = 1'b1;
    check({7'h00, irq_n}, 8'h01, "irq after reset");
    foreach (rows[i]) begin
      if (rows[i].wr) host.write_reg(rows[i].addr, rows[i].wdata);
      rd_chk(rows[i].addr, rows[i].exp);
    end
    $display("test register table done");
    host.write_reg(8'h19, 8'h06);
    ilim = 3'b001;
    wait_irq(1'b0);
    rd_chk(8'h1a, 8'h01);
    rd_chk(8'h18, 8'h01);
    wait_irq(1'b1);
    ilim = 3'b011;
    repeat (10) @(negedge i_ref_clk);
    check({7'h00, irq_n}, 8'h01, "masked fault");
    rd_chk(8'h18, 8'h02);
    ilim = 3'b000;
    repeat (6) @(negedge i_ref_clk);
    rd_chk(8'h1a, 8'h00);
    rd_chk(8'h18, 8'h00);
    host.write_reg(8'h19, 8'h02);
    ilim = 3'b100;
    wait_irq(1'b0);
    host.write_reg(8'h18, 8'h00);
    check({7'h00, irq_n}, 8'h00, "write zero kept");
    host.write_reg(8'h18, 8'h04);
    check({7'h00, irq_n}, 8'h01, "write one cleared");
    rd_chk(8'h18, 8'h00);
    ilim = 3'b000;
    $display("test regulator done");
    for (int i = 0; i < 4; i++) begin
      {crit, warn} = tw[i];
      wait_irq(1'b0);
      rd_chk(8'h22, {5'h00, tw[i][1], 1'b0, tw[i][0]});
      rd_chk(8'h20, exp_t[i]);
    end
    $display("test thermal done");
    host.write_reg(8'h25, 8'h3e);
    btn_n = 1'b0;
    repeat (4) @(negedge i_ref_clk);
    btn_n = 1'b1;
    repeat (20) @(negedge i_ref_clk);
    rd_chk(8'h24, 8'h00);
    btn_n = 1'b0;
    wait_irq(1'b0);
    rd_chk(8'h24, 8'h01);
    repeat (200) @(negedge i_ref_clk);
    check({7'h00, irq_n}, 8'h01, "hold masked");
    rd_chk(8'h26, 8'h3f);
    rd_chk(8'h24, 8'h3e);
    repeat (20) @(negedge i_ref_clk);
    rd_chk(8'h24, 8'h00);
    btn_n = 1'b1;
    wait_irq(1'b0);
    rd_chk(8'h26, 8'h00);
    rd_chk(8'h24, 8'h01);
    host.write_reg(8'h25, 8'h3d);
    btn_n = 1'b0;
    wait_irq(1'b0);
    rd_chk(8'h26, 8'h03);
    rd_chk(8'h24, 8'h03);
    btn_n = 1'b1;
    $display("test button done");
    @(negedge i_ref_clk) i_rst_n = 1'b0;
    #1;
    check({7'h00, irq_n}, 8'h01, "irq in reset");
    repeat (2) @(negedge i_ref_clk);
    i_rst_n = 1'b1;
    rd_chk(8'h25, 8'h3f);
    rd_chk(8'h24, 8'h00);
    $display("test second reset done");
    finish_test;
  end
endmodule
`default_nettype wire
